/* File: hw/dpgpw_params.svh */
// Register indices, field positions, masks and reset values for the dual-port GPIO block.
`ifndef DPGPW_PARAMS_SVH
`define DPGPW_PARAMS_SVH

`define DPGPW_IDX_PA_DATA   4'h0
`define DPGPW_IDX_PA_DIR    4'h1
`define DPGPW_IDX_PA_PU     4'h2
`define DPGPW_IDX_PA_WAKE   4'h3
`define DPGPW_IDX_PB_DATA   4'h4
`define DPGPW_IDX_PB_DIR    4'h5
`define DPGPW_IDX_PB_PU     4'h6
`define DPGPW_IDX_STRONG_PULLUP_SELECT      4'h7
`define DPGPW_IDX_SRC_CUR   4'h8

`define DPGPW_PA_MASK       8'hFB
`define DPGPW_PA_DATA_MASK  8'hFF
`define DPGPW_PB_MASK       8'h3F
`define DPGPW_STRONG_PULLUP_SELECT_MASK     8'h01
`define DPGPW_STRONG_PULLUP_SELECT_BIT      0

`define DPGPW_DIR_RESET     8'hFF
`define DPGPW_ZERO_RESET    8'h00

`define DPGPW_SC_PA_LO      1:0
`define DPGPW_SC_PA_HI      3:2
`define DPGPW_SC_PB_LO      5:4
`define DPGPW_SC_PB_HI      7:6

`define DPGPW_NO_PULL_PIN   2

`endif

/* File: hw/dpgpw_pkg.sv */
// Types shared by the dual-port GPIO block.
package dpgpw_pkg;
  typedef enum logic [1:0] {
    DPGPW_FN_GPIO_IN  = 2'b00,
    DPGPW_FN_GPIO_OUT = 2'b01,
    DPGPW_FN_OPEN_DRN = 2'b10,
    DPGPW_FN_OTHER    = 2'b11
  } dpgpw_fn_t;
  typedef logic [1:0] dpgpw_level_t;
endpackage : dpgpw_pkg

/* File: hw/dpgpw_pull.sv */
// Pull-up gating for one port.
`timescale 1ns/10ps
`include "dpgpw_params.svh"
module dpgpw_pull #(
  parameter int          N    = 8,
  parameter logic [7:0]  MASK = 8'hFF
) (
  // Configuration
  input  wire logic [N-1:0]   pu_en,
  input  wire logic [2*N-1:0] fn_sel,
  // Result
  output logic      [N-1:0]   pull_on
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_pin
      dpgpw_pkg::dpgpw_fn_t f;
      assign f = dpgpw_pkg::dpgpw_fn_t'(fn_sel[2*i+1:2*i]);
      // Only digital input and open-drain may carry a pull-up.
      assign pull_on[i] = pu_en[i] & MASK[i] &
                          ((f == dpgpw_pkg::DPGPW_FN_GPIO_IN) |
                           (f == dpgpw_pkg::DPGPW_FN_OPEN_DRN));
    end
  endgenerate
endmodule : dpgpw_pull

/* File: hw/dpgpw_wake.sv */
// Falling-edge wake detection on port A.
`timescale 1ns/10ps
`include "dpgpw_params.svh"
module dpgpw_wake (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Pins and configuration
  input  wire logic [7:0] pin_in,
  input  wire logic [7:0] wake_en,
  input  wire logic [7:0] is_input,
  input  wire logic       halted,
  // Event
  output logic            wake_req
);
  logic [7:0] prev_reg;
  logic [7:0] fall;
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 8'hFF;
    end else begin
      prev_reg <= pin_in;
    end
  end
  // Pin 2 has no wake path; other pins need input mode and a halted core.
  assign fall = prev_reg & ~pin_in & wake_en & is_input & `DPGPW_PA_MASK;
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= halted & (|fall);
    end
  end
endmodule : dpgpw_wake

/* File: hw/dpgpw_top.sv */
// Dual-port GPIO with pull-ups, wake-up and source-current select.
// Contract
// - Port reads take the live pin level of input pins in the read cycle, not latched.
// - Written data sits in an output latch until software writes again.
// - Unimplemented bits in data, direction, pull-up, low-voltage registers read zero.
// - Pull-up bit 0 turns weak pull-up off, 1 turns it on, per pin.
// - Pull-up acts only for digital input or open-drain function.
// - Port A pin 2 has no pull-up and no wake-up.
// - One select bit picks weak (0) or strong (1) pull-up for enabled pins.
// - In sleep or idle, a falling edge on wake-enabled port A pin wakes core.
// - Wake honoured only for general-purpose inputs while core is halted.
// - Port A wake register has one enable bit per pin, bits 7 to 0 except bit 2.
// - Direction bit 0 gives push-pull output, 1 gives input, changeable anytime.
// - Reading an output pin returns the output latch, not the pin.
// - Source-current register holds 2-bit levels; bits 7~6 drive port B pins 5,4.
// - Bits 3~2 drive port A pins 7-4, bits 1~0 port A pins 3-0.
// - Two ports, A with 8 pins and B with 6, each pin in and out except port A pin 2, output only.
// - Pull-up, wake, low-voltage select and source-current reset to zero.
`timescale 1ns/10ps
`include "dpgpw_params.svh"
module dpgpw_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Core data-memory access
  input  wire logic [3:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // Core power state and pin-shared selection
  input  wire logic        core_halted,
  input  wire logic [15:0] pa_fn_sel,
  input  wire logic [11:0] pb_fn_sel,
  output logic             wake_req,
  // Port A pins
  input  wire logic [7:0]  pa_in,
  output logic      [7:0]  pa_out,
  output logic      [7:0]  pa_oe,
  output logic      [7:0]  pa_pull_en,
  // Port B pins
  input  wire logic [5:0]  pb_in,
  output logic      [5:0]  pb_out,
  output logic      [5:0]  pb_oe,
  output logic      [5:0]  pb_pull_en,
  // Analog controls
  output logic             pull_strong,
  output logic      [1:0]  src_pa_lo,
  output logic      [1:0]  src_pa_hi,
  output logic      [1:0]  src_pb_lo,
  output logic      [1:0]  src_pb_hi
);
  logic [7:0] pa_data_reg;
  logic [7:0] pa_dir_reg;
  logic [7:0] pa_pu_reg;
  logic [7:0] pa_wake_reg;
  logic [5:0] pb_data_reg;
  logic [5:0] pb_dir_reg;
  logic [5:0] pb_pu_reg;
  logic       strong_pullup_select_reg;
  logic [7:0] src_reg;
  logic [7:0] rdata_next;
  logic [7:0] pa_pull_c;
  logic [5:0] pb_pull_c;
  logic       wake_c;
  logic [7:0] pa_gpin_c;
  logic [7:0] pa_view_c;

  // Mixes latch and pin per bit: input pins show the pin, output pins the latch.
  function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] latch,
                                           input logic [7:0] pins, input logic [7:0] mask);
    port_view = ((dir & pins) | (~dir & latch)) & mask;
  endfunction : port_view

  function automatic logic hit(input logic [3:0] idx);
    hit = reg_wr && (reg_addr == idx);
  endfunction : hit

  always_ff @(posedge clk) begin
    if (rst) begin
      pa_data_reg <= `DPGPW_ZERO_RESET;
      pb_data_reg <= 6'h00;
    end else begin
      if (hit(`DPGPW_IDX_PA_DATA)) begin
        pa_data_reg <= reg_wdata;
      end
      if (hit(`DPGPW_IDX_PB_DATA)) begin
        pb_data_reg <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pa_dir_reg <= `DPGPW_DIR_RESET & `DPGPW_PA_MASK;
      pb_dir_reg <= 6'h3F;
    end else begin
      if (hit(`DPGPW_IDX_PA_DIR)) begin
        pa_dir_reg <= reg_wdata & `DPGPW_PA_MASK;
      end
      if (hit(`DPGPW_IDX_PB_DIR)) begin
        pb_dir_reg <= reg_wdata[5:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pa_pu_reg   <= `DPGPW_ZERO_RESET;
      pb_pu_reg   <= 6'h00;
      pa_wake_reg <= `DPGPW_ZERO_RESET;
      strong_pullup_select_reg    <= 1'b0;
      src_reg     <= `DPGPW_ZERO_RESET;
    end else begin
      if (hit(`DPGPW_IDX_PA_PU)) begin
        pa_pu_reg <= reg_wdata & `DPGPW_PA_MASK;
      end
      if (hit(`DPGPW_IDX_PB_PU)) begin
        pb_pu_reg <= reg_wdata[5:0];
      end
      if (hit(`DPGPW_IDX_PA_WAKE)) begin
        pa_wake_reg <= reg_wdata & `DPGPW_PA_MASK;
      end
      if (hit(`DPGPW_IDX_STRONG_PULLUP_SELECT)) begin
        strong_pullup_select_reg <= reg_wdata[`DPGPW_STRONG_PULLUP_SELECT_BIT];
      end
      if (hit(`DPGPW_IDX_SRC_CUR)) begin
        src_reg <= reg_wdata;
      end
    end
  end

  // Read data is captured from live input pins and the output latch in the read cycle, never held from earlier.
  always_comb begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      `DPGPW_IDX_PA_DATA: rdata_next = port_view(pa_dir_reg, pa_data_reg, pa_in,
                                                 `DPGPW_PA_DATA_MASK);
      `DPGPW_IDX_PA_DIR:  rdata_next = pa_dir_reg;
      `DPGPW_IDX_PA_PU:   rdata_next = pa_pu_reg;
      `DPGPW_IDX_PA_WAKE: rdata_next = pa_wake_reg;
      `DPGPW_IDX_PB_DATA: rdata_next = port_view({2'b00, pb_dir_reg}, {2'b00, pb_data_reg},
                                                 {2'b00, pb_in}, `DPGPW_PB_MASK);
      `DPGPW_IDX_PB_DIR:  rdata_next = {2'b00, pb_dir_reg};
      `DPGPW_IDX_PB_PU:   rdata_next = {2'b00, pb_pu_reg};
      `DPGPW_IDX_STRONG_PULLUP_SELECT:    rdata_next = {7'h00, strong_pullup_select_reg};
      `DPGPW_IDX_SRC_CUR: rdata_next = src_reg;
      default:            rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end
  end

  dpgpw_pull #(.N(8), .MASK(`DPGPW_PA_MASK)) u_pull_a (
    .pu_en   (pa_pu_reg),
    .fn_sel  (pa_fn_sel),
    .pull_on (pa_pull_c)
  );

  dpgpw_pull #(.N(6), .MASK(8'h3F)) u_pull_b (
    .pu_en   (pb_pu_reg),
    .fn_sel  (pb_fn_sel),
    .pull_on (pb_pull_c)
  );

  // A pin handed to another function is no general-purpose input, so it cannot wake.
  for (genvar g = 0; g < 8; g++) begin : g_gpin
    assign pa_gpin_c[g] = pa_dir_reg[g] &
                          (pa_fn_sel[2*g+1:2*g] == dpgpw_pkg::DPGPW_FN_GPIO_IN);
  end

  // Expected port A read, built apart from the read mux so that its check is independent.
  assign pa_view_c = (pa_dir_reg & pa_in) | (~pa_dir_reg & pa_data_reg);

  dpgpw_wake u_wake (
    .clk      (clk),
    .rst      (rst),
    .pin_in   (pa_in),
    .wake_en  (pa_wake_reg),
    .is_input (pa_gpin_c),
    .halted   (core_halted),
    .wake_req (wake_c)
  );

  // Pin drivers are registered so outputs never glitch on decode changes.
  always_ff @(posedge clk) begin
    if (rst) begin
      pa_out     <= 8'h00;
      pa_oe      <= 8'h00;
      pb_out     <= 6'h00;
      pb_oe      <= 6'h00;
      pa_pull_en <= 8'h00;
      pb_pull_en <= 6'h00;
    end else begin
      pa_out     <= pa_data_reg;
      pa_oe      <= ~pa_dir_reg;
      pb_out     <= pb_data_reg;
      pb_oe      <= ~pb_dir_reg;
      pa_pull_en <= pa_pull_c;
      pb_pull_en <= pb_pull_c;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pull_strong <= 1'b0;
      src_pa_lo   <= 2'b00;
      src_pa_hi   <= 2'b00;
      src_pb_lo   <= 2'b00;
      src_pb_hi   <= 2'b00;
      wake_req    <= 1'b0;
    end else begin
      // Strength matters only where a pull-up is on, so gate it by any enabled pull.
      pull_strong <= strong_pullup_select_reg & ((|pa_pull_c) | (|pb_pull_c));
      src_pa_lo   <= src_reg[`DPGPW_SC_PA_LO];
      src_pa_hi   <= src_reg[`DPGPW_SC_PA_HI];
      src_pb_lo   <= src_reg[`DPGPW_SC_PB_LO];
      src_pb_hi   <= src_reg[`DPGPW_SC_PB_HI];
      wake_req    <= wake_c;
    end
  end

  property p_read_live;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `DPGPW_IDX_PA_DATA |=> reg_rdata == $past(pa_view_c);
  endproperty
  a_read_live: assert property (p_read_live) else $error("port A read wrong");

  property p_latch_hold;
    @(posedge clk) disable iff (rst)
      !hit(`DPGPW_IDX_PA_DATA) |=> pa_data_reg == $past(pa_data_reg);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch changed");

  property p_pb_zero;
    @(posedge clk) disable iff (rst)
      reg_rd && reg_addr == `DPGPW_IDX_PB_DIR |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_pb_zero: assert property (p_pb_zero) else $error("unimplemented bits set");

  property p_pin2;
    @(posedge clk) disable iff (rst) !pa_pull_en[2] && !pa_wake_reg[2] && !pa_dir_reg[2];
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 has pull or wake");

  property p_pull_fn;
    @(posedge clk) disable iff (rst)
      pa_fn_sel[1:0] == 2'h3 || pa_fn_sel[1:0] == 2'h1 |=> !pa_pull_en[0];
  endproperty
  a_pull_fn: assert property (p_pull_fn) else $error("pull-up on wrong function");

  property p_wake;
    @(posedge clk) disable iff (rst) wake_req |-> $past(core_halted, 2);
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside halt");

  property p_oe;
    @(posedge clk) disable iff (rst)
      hit(`DPGPW_IDX_PB_DIR) |=> ##1 pb_oe == ~$past(reg_wdata[5:0], 2);
  endproperty
  a_oe: assert property (p_oe) else $error("direction not applied");

  property p_src;
    @(posedge clk) disable iff (rst)
      hit(`DPGPW_IDX_SRC_CUR) |=> ##1 src_pb_hi == $past(reg_wdata[7:6], 2);
  endproperty
  a_src: assert property (p_src) else $error("source level wrong");

  property p_strong;
    @(posedge clk) disable iff (rst) pull_strong |-> $past(strong_pullup_select_reg);
  endproperty
  a_strong: assert property (p_strong) else $error("strong pull without select");

  property p_pa_oe;
    @(posedge clk) disable iff (rst)
      hit(`DPGPW_IDX_PA_DIR) |=> ##1 pa_oe == ~($past(reg_wdata, 2) & `DPGPW_PA_MASK);
  endproperty
  a_pa_oe: assert property (p_pa_oe) else $error("port A direction not applied");

  property p_pull_fn_b;
    @(posedge clk) disable iff (rst)
      pb_fn_sel[1:0] == 2'h3 || pb_fn_sel[1:0] == 2'h1 |=> !pb_pull_en[0];
  endproperty
  a_pull_fn_b: assert property (p_pull_fn_b) else $error("port B pull on wrong function");

  property p_strong_on;
    @(posedge clk) disable iff (rst)
      strong_pullup_select_reg && ((|pa_pull_c) || (|pb_pull_c)) |=> pull_strong;
  endproperty
  a_strong_on: assert property (p_strong_on) else $error("strong pull not applied");

  property p_src_pa;
    @(posedge clk) disable iff (rst)
      hit(`DPGPW_IDX_SRC_CUR) |=> ##1 {src_pa_hi, src_pa_lo} == $past(reg_wdata[3:0], 2);
  endproperty
  a_src_pa: assert property (p_src_pa) else $error("port A source level wrong");

  property p_dir_reset;
    @(posedge clk)
      rst |=> pa_dir_reg == (`DPGPW_DIR_RESET & `DPGPW_PA_MASK) && pb_dir_reg == 6'h3F;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction reset wrong");

  property p_zero_reset;
    @(posedge clk)
      rst |=> pa_pu_reg == 8'h00 && pb_pu_reg == 6'h00 && pa_wake_reg == 8'h00 &&
              !strong_pullup_select_reg && src_reg == 8'h00;
  endproperty
  a_zero_reset: assert property (p_zero_reset) else $error("control reset wrong");

  c_wake:  cover property (@(posedge clk) disable iff (rst) wake_req);
  c_read:  cover property (@(posedge clk) disable iff (rst)
                           reg_rd && reg_addr == 4'h0 && pa_dir_reg != 8'h00);
  c_pull:  cover property (@(posedge clk) disable iff (rst) pull_strong);
  c_pull_fn: cover property (@(posedge clk) disable iff (rst) pa_pull_c != pa_pu_reg);
endmodule : dpgpw_top

/* File: tb/dpgpw_pins_model.sv */
// Board-side model of the port pins: switches, weak pull-ups and floating lines.
`timescale 1ns/10ps
module dpgpw_pins_model (
  // Clock
  input  wire logic       clk,
  // Device side
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] pa_pull_en,
  input  wire logic [5:0] pb_out,
  input  wire logic [5:0] pb_oe,
  input  wire logic [5:0] pb_pull_en,
  // Switches on the board
  input  wire logic [7:0] pa_sw_en,
  input  wire logic [7:0] pa_sw_val,
  input  wire logic [5:0] pb_sw_en,
  input  wire logic [5:0] pb_sw_val,
  // Pin levels
  output logic      [7:0] pa_in,
  output logic      [5:0] pb_in
);
  logic [7:0] pa_last_reg = 8'h00;
  logic [5:0] pb_last_reg = 6'h00;
  // A line with no driver and no pull-up toggles every cycle, so a stale level can never pass.
  always_comb begin
    pa_in = (pa_oe & pa_out) | (~pa_oe & pa_sw_en & pa_sw_val)
          | (~pa_oe & ~pa_sw_en & (pa_pull_en | ~pa_last_reg));
    pb_in = (pb_oe & pb_out) | (~pb_oe & pb_sw_en & pb_sw_val)
          | (~pb_oe & ~pb_sw_en & (pb_pull_en | ~pb_last_reg));
  end
  always_ff @(posedge clk) begin
    pa_last_reg <= pa_in;
    pb_last_reg <= pb_in;
  end
endmodule : dpgpw_pins_model

/* File: tb/dpgpw_top_bench.sv */
// Self-checking bench for the dual-port GPIO block.
`timescale 1ns/10ps
`include "dpgpw_params.svh"
module dpgpw_top_bench;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  reg_addr = 4'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        core_halted = 1'h0;
  logic [15:0] pa_fn_sel = 16'h0000;
  logic [11:0] pb_fn_sel = 12'h000;
  logic [7:0]  pa_sw_en = 8'h00;
  logic [7:0]  pa_sw_val = 8'h00;
  logic [5:0]  pb_sw_en = 6'h00;
  logic [5:0]  pb_sw_val = 6'h00;
  logic [7:0]  reg_rdata, pa_in, pa_out, pa_oe, pa_pull_en;
  logic [5:0]  pb_in, pb_out, pb_oe, pb_pull_en;
  logic [1:0]  src_pa_lo, src_pa_hi, src_pb_lo, src_pb_hi;
  logic        wake_req, pull_strong;
  int          n_fail = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [3:0]  ridx [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
  logic [7:0]  rst_exp [8] = '{8'hFB, 8'h00, 8'h00, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  one_exp [8] = '{8'hFB, 8'hFB, 8'hFB, 8'h3F, 8'h3F, 8'h01, 8'hFF, 8'h00};

  dpgpw_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_halted(core_halted), .pa_fn_sel(pa_fn_sel), .pb_fn_sel(pb_fn_sel),
    .wake_req(wake_req), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pull_en(pa_pull_en), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pull_en(pb_pull_en), .pull_strong(pull_strong), .src_pa_lo(src_pa_lo),
    .src_pa_hi(src_pa_hi), .src_pb_lo(src_pb_lo), .src_pb_hi(src_pb_hi));
  dpgpw_pins_model i_pins (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_pull_en(pa_pull_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pull_en(pb_pull_en),
    .pa_sw_en(pa_sw_en), .pa_sw_val(pa_sw_val), .pb_sw_en(pb_sw_en),
    .pb_sw_val(pb_sw_val), .pa_in(pa_in), .pb_in(pb_in));

  always #10 clk = ~clk;

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // The whole run needs well under a thousand cycles; a hang stops here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("ERROR %0t timeout", $time);
      end_sim();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge clk) #1;
    reg_wr = 1'h0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge clk) #1;
    reg_rd = 1'h0;
    chk(reg_rdata, exp, "read");
  endtask : rd

  // Pin outputs follow a register write two edges later.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic wake_chk(input logic exp);
    logic seen;
    seen = 1'h0;
    repeat (4) begin
      @(posedge clk) #1;
      if (wake_req === 1'h1) seen = 1'h1;
    end
    chk({7'h00, seen}, {7'h00, exp}, "wake");
  endtask : wake_chk

  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 1'h0;
    for (int i = 0; i < 8; i++) rd(ridx[i], rst_exp[i]);
    for (int i = 0; i < 8; i++) begin
      wr(ridx[i], 8'hFF);
      rd(ridx[i], one_exp[i]);
    end
    settle();
    chk(pa_pull_en, 8'hFB, "pull a");
    chk({2'h0, pb_pull_en}, 8'h3F, "pull b");
    chk({7'h00, pull_strong}, 8'h01, "strong");
    pa_fn_sel = 16'h004B;
    pb_fn_sel = 12'h02D;
    settle();
    chk(pa_pull_en, 8'hF2, "pull fn");
    chk({2'h0, pb_pull_en}, 8'h3C, "pull fn b");
    wr(`DPGPW_IDX_STRONG_PULLUP_SELECT, 8'h00);
    settle();
    chk({7'h00, pull_strong}, 8'h00, "weak");
    for (int i = 0; i < 8; i++) wr(ridx[i], rst_exp[i]);
    pa_fn_sel = 16'h0000;
    pb_fn_sel = 12'h000;
    wr(`DPGPW_IDX_SRC_CUR, 8'hE4);
    settle();
    chk({src_pb_hi, src_pb_lo, src_pa_hi, src_pa_lo}, 8'hE4, "source");
    wr(`DPGPW_IDX_PA_DIR, 8'h00);
    wr(`DPGPW_IDX_PA_DATA, 8'hA5);
    settle();
    chk(pa_oe, 8'hFF, "oe");
    chk(pa_out, 8'hA5, "latch");
    rd(`DPGPW_IDX_PA_DATA, 8'hA5);
    repeat (20) @(posedge clk);
    #1;
    chk(pa_out, 8'hA5, "held");
    wr(`DPGPW_IDX_PB_DIR, 8'h00);
    wr(`DPGPW_IDX_PB_DATA, 8'hFF);
    rd(`DPGPW_IDX_PB_DATA, 8'h3F);
    chk({2'h0, pb_out}, 8'h3F, "pb latch");
    chk({2'h0, pb_oe}, 8'h3F, "pb oe");
    wr(`DPGPW_IDX_PB_DIR, 8'h3F);
    pb_sw_en = 6'h3F;
    pb_sw_val = 6'h2A;
    rd(`DPGPW_IDX_PB_DATA, 8'h2A);
    wr(`DPGPW_IDX_PA_DIR, 8'hFB);
    pa_sw_en = 8'hFB;
    pa_sw_val = 8'h3C;
    rd(`DPGPW_IDX_PA_DATA, 8'h3C);
    pa_sw_val = 8'hC3;
    rd(`DPGPW_IDX_PA_DATA, 8'hC7);
    pa_sw_val = 8'hFF;
    wr(`DPGPW_IDX_PA_WAKE, 8'hFF);
    core_halted = 1'h1;
    settle();
    pa_sw_val = 8'hEF;
    wake_chk(1'h1);
    pa_sw_val = 8'hFF;
    pa_fn_sel = 16'h0300;
    settle();
    pa_sw_val = 8'hEF;
    wake_chk(1'h0);
    pa_fn_sel = 16'h0000;
    pa_sw_val = 8'hFF;
    core_halted = 1'h0;
    settle();
    pa_sw_val = 8'hDF;
    wake_chk(1'h0);
    pa_sw_val = 8'hFF;
    pa_sw_en = 8'hBB;
    wr(`DPGPW_IDX_PA_DIR, 8'hBB);
    wr(`DPGPW_IDX_PA_DATA, 8'hFF);
    core_halted = 1'h1;
    settle();
    wr(`DPGPW_IDX_PA_DATA, 8'hBB);
    wake_chk(1'h0);
    end_sim();
  end
endmodule : dpgpw_top_bench
